//--- mpse_engine.sv
// Motion setpoint engine: profile position handshake and velocity mode ramp
`timescale 1ns/1ps

// Operation
// - Valid request sets acknowledge and starts move
// - Target reached flag set on arrival
// - Option bits 4,5 make device clear trigger
// - Acknowledge drops when buffer can accept again
// - One further command buffered during move
// - Request without immediate bit ignored while buffer is full
// - Immediate bit bypasses buffer, replaces target
// - Bit 9 holds profile speed through target
// - Option zero: relative to preceding target
// - Millisecond sample bases next relative move
// - Speed limited by smaller of two maxima
// - Profile type 3 enforces four jerk limits
// - Profile acceleration and deceleration capped by maxima; quick stop uses qs_dec uncapped
// - Quick stop brakes with quick-stop deceleration
// - Mode value 2 selects plain velocity mode
// - Halt edges brake or accelerate on ramps
// - Speed scaled to rpm by multiplier/divisor
// - Velocity ramps are speed delta per seconds
// - Velocity target clamped to min and max
// - Ramp tracks target; bit 11 while limiting
// - Mode value 1 selects profile position
// - Travel starts on rising trigger bit
// - Bit 6 selects absolute or relative target
// - Moves and handshake processed on the 1 ms tick; leaving a mode resets state in any cycle
module mpse_engine #(
	parameter int unsigned P_TICK_CYC = mpse_pkg::TICK_CYC
) (
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst_n,
	input  wire logic [7:0]           i_mode_op,
	input  wire logic [15:0]          i_ctrl_word,
	input  wire logic                 i_quick_stop,
	input  wire logic signed [31:0]   i_target_pos,
	input  wire logic signed [31:0]   i_actual_pos,
	input  wire mpse_pkg::mpse_pp_cfg_s i_pp,
	input  wire mpse_pkg::mpse_vl_cfg_s i_vl,
	output logic [15:0]               o_status_word,
	output logic                      o_trig_clear,
	output logic signed [31:0]        o_demand_pos,
	output logic signed [31:0]        o_demand_vel,
	output logic signed [31:0]        o_vel_rpm
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		umin = (a < b) ? a : b;
	endfunction : umin

	function automatic logic [31:0] sabs(input logic signed [31:0] a);
		sabs = a[31] ? 32'(-a) : 32'(a);
	endfunction : sabs

	// Speed step per tick from delta speed over delta seconds
	function automatic logic [31:0] rate_per_tick(input logic [31:0] dv, input logic [31:0] dt);
		logic [63:0] den;
		den = 64'(dt) * 64'(mpse_pkg::TICKS_PER_S);
		if (den == 64'h0)
			rate_per_tick = dv;
		else
			rate_per_tick = 32'(64'(dv) / den);
	endfunction : rate_per_tick

	// Acceleration moves toward its goal by at most the jerk step when jerk limited
	function automatic logic [31:0] jerk_step(input logic [31:0] now, input logic [31:0] goal,
			input logic [31:0] j_up, input logic [31:0] j_dn, input logic lim_on);
		logic [32:0] up;
		up = 33'(now) + 33'(j_up);
		if (!lim_on)
			jerk_step = goal;
		else if (goal > now)
			jerk_step = (up > 33'(goal)) ? goal : up[31:0];
		else
			jerk_step = (now - goal > j_dn) ? now - j_dn : goal;
	endfunction : jerk_step

	////////////////////////////////////////////////////////////////////////////////
	// Application tick

	logic [31:0] tick_cnt_reg;
	logic        tick_reg;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			tick_cnt_reg <= 32'h0;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == 32'(P_TICK_CYC - 1)) begin
			tick_cnt_reg <= 32'h0;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
			tick_reg     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Setpoint handshake

	mpse_pkg::mpse_mv_e  mv_state_reg;
	mpse_pkg::mpse_move_s cur_reg, buf_reg, new_move;
	logic                buf_valid_reg, ack_reg, reached_reg, reach_evt_reg;
	logic                trig_prev_reg, auto_clr_reg, trig_clr_reg;
	logic signed [31:0]  last_tgt_reg, pos_sample_reg, reach_sample_reg;
	logic                reach_ok_reg, last_endv_nz_reg;
	logic                pp_mode, vl_mode, trig_eff, new_sp, valid, take_now, take_buf;
	logic                auto_opt, arrive;
	logic signed [31:0]  base_pos, abs_tgt;

	assign pp_mode  = (i_mode_op == mpse_pkg::MODE_PP);
	assign vl_mode  = (i_mode_op == mpse_pkg::MODE_VL);
	assign auto_opt = |i_pp.pos_option[mpse_pkg::POC_CLR_HI:mpse_pkg::POC_CLR_LO];
	assign trig_eff = i_ctrl_word[mpse_pkg::CW_NEW_SP] & ~auto_clr_reg;
	// Trigger seen as low outside this mode, so a bit already set on entry starts a move
	assign new_sp   = tick_reg & pp_mode & trig_eff & ~trig_prev_reg;
	assign valid    = (umin(umin(i_pp.prof_vel, i_pp.max_prof_vel), i_pp.max_motor_speed)
		!= 32'h0);

	always_comb begin
		if (i_pp.pos_option != mpse_pkg::POC_REL_PREV)
			base_pos = pos_sample_reg;
		else if (last_endv_nz_reg && reach_ok_reg)
			base_pos = reach_sample_reg;
		else
			base_pos = last_tgt_reg;
		abs_tgt = i_ctrl_word[mpse_pkg::CW_RELATIVE] ? 32'(base_pos + i_target_pos)
			: i_target_pos;
		new_move = '{abs_tgt, i_pp.prof_vel, i_pp.end_vel, i_pp.prof_acc, i_pp.prof_dec};
	end

	assign take_now = new_sp & valid & ((mv_state_reg == mpse_pkg::MPSE_IDLE)
		| i_ctrl_word[mpse_pkg::CW_IMMED]);
	assign take_buf = new_sp & valid & (mv_state_reg == mpse_pkg::MPSE_RUN)
		& ~i_ctrl_word[mpse_pkg::CW_IMMED] & ~buf_valid_reg;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			trig_prev_reg <= 1'b0;
			auto_clr_reg  <= 1'b0;
			trig_clr_reg  <= 1'b0;
		end else begin
			if (tick_reg)
				trig_prev_reg <= pp_mode ? trig_eff : 1'b0;
			trig_clr_reg <= (take_now | take_buf) & auto_opt;
			if ((take_now | take_buf) & auto_opt)
				auto_clr_reg <= 1'b1;
			else if (tick_reg & ~i_ctrl_word[mpse_pkg::CW_NEW_SP])
				auto_clr_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			mv_state_reg  <= mpse_pkg::MPSE_IDLE;
			cur_reg       <= '0;
			buf_reg       <= '0;
			buf_valid_reg <= 1'b0;
			reached_reg   <= 1'b0;
			reach_evt_reg <= 1'b0;
			last_tgt_reg  <= 32'h0;
		end else if (!pp_mode) begin
			mv_state_reg  <= mpse_pkg::MPSE_IDLE;
			buf_valid_reg <= 1'b0;
			reach_evt_reg <= 1'b0;
		end else begin
			reach_evt_reg <= 1'b0;
			if (take_now) begin
				cur_reg       <= new_move;
				buf_valid_reg <= 1'b0;
				mv_state_reg  <= mpse_pkg::MPSE_RUN;
				reached_reg   <= 1'b0;
				last_tgt_reg  <= abs_tgt;
			end else if (take_buf) begin
				buf_reg       <= new_move;
				buf_valid_reg <= 1'b1;
				last_tgt_reg  <= abs_tgt;
			end else if (tick_reg && mv_state_reg == mpse_pkg::MPSE_RUN && arrive) begin
				reach_evt_reg <= 1'b1;
				if (buf_valid_reg) begin
					cur_reg       <= buf_reg;
					buf_valid_reg <= 1'b0;
				end else begin
					mv_state_reg <= mpse_pkg::MPSE_IDLE;
					reached_reg  <= 1'b1;
				end
			end
		end
	end

	// Acceptance wins over the release of the acknowledge in the same cycle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			ack_reg <= 1'b0;
		else if (take_now | take_buf)
			ack_reg <= 1'b1;
		else if (tick_reg & ~trig_eff & ~buf_valid_reg)
			ack_reg <= 1'b0;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pos_sample_reg   <= 32'h0;
			reach_sample_reg <= 32'h0;
			reach_ok_reg     <= 1'b0;
			last_endv_nz_reg <= 1'b0;
		end else begin
			if (tick_reg)
				pos_sample_reg <= i_actual_pos;
			if (take_now | take_buf) begin
				reach_ok_reg     <= 1'b0;
				last_endv_nz_reg <= (i_pp.end_vel != 32'h0);
			end else if (tick_reg & reach_evt_reg) begin
				reach_sample_reg <= i_actual_pos;
				reach_ok_reg     <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Profile position trajectory, one step per tick

	logic signed [31:0] pos_reg;
	logic [31:0]        spd_reg, acc_now_reg;
	logic               dir_reg;
	logic signed [32:0] dist_s;
	logic [31:0]        dist_m, v_lim, a_lim, d_lim, end_sp, acc_goal, acc_step, spd_next;
	logic               dir_want, wrong_dir, brake, jerk_on;
	logic [63:0]        kin_now, kin_end;

	always_comb begin
		jerk_on   = (i_pp.prof_type == mpse_pkg::PROF_JERK);
		dist_s    = 33'(cur_reg.target) - 33'(pos_reg);
		dir_want  = dist_s[32];
		dist_m    = dist_s[32] ? 32'(-dist_s) : 32'(dist_s);
		v_lim     = umin(umin(cur_reg.vel, i_pp.max_prof_vel), i_pp.max_motor_speed);
		a_lim     = umin(cur_reg.acc, i_pp.max_acc);
		d_lim     = i_quick_stop ? i_pp.qs_dec : umin(cur_reg.dec, i_pp.max_dec);
		end_sp    = (buf_valid_reg & i_ctrl_word[mpse_pkg::CW_CHG_ON_SP]) ? v_lim
			: umin(cur_reg.end_vel, v_lim);
		wrong_dir = (spd_reg != 32'h0) && (dir_reg != dir_want);
		kin_now   = 64'(spd_reg) * 64'(spd_reg);
		kin_end   = 64'(end_sp) * 64'(end_sp) + 64'(d_lim) * 64'(dist_m) * 64'h2;
		brake     = i_quick_stop | i_ctrl_word[mpse_pkg::CW_HALT] | wrong_dir
			| (kin_now >= kin_end) | (spd_reg > v_lim);
		if (brake)
			acc_goal = d_lim;
		else if (spd_reg < v_lim)
			acc_goal = a_lim;
		else
			acc_goal = 32'h0;
		if (brake)
			acc_step = jerk_step(acc_now_reg, acc_goal, i_pp.jerk[2], i_pp.jerk[3], jerk_on);
		else
			acc_step = jerk_step(acc_now_reg, acc_goal, i_pp.jerk[0], i_pp.jerk[1], jerk_on);
		if (brake)
			spd_next = spd_reg - umin(spd_reg, acc_step);
		else
			spd_next = umin(32'(33'(spd_reg) + 33'(acc_step)), v_lim);
		arrive    = ~wrong_dir & ~i_quick_stop & ~i_ctrl_word[mpse_pkg::CW_HALT]
			& (dist_m <= spd_next);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pos_reg     <= 32'h0;
			spd_reg     <= 32'h0;
			acc_now_reg <= 32'h0;
			dir_reg     <= 1'b0;
		end else if (!pp_mode) begin
			pos_reg     <= i_actual_pos;
			spd_reg     <= 32'h0;
			acc_now_reg <= 32'h0;
		end else if (tick_reg && mv_state_reg == mpse_pkg::MPSE_RUN) begin
			acc_now_reg <= acc_step;
			if (arrive) begin
				pos_reg <= cur_reg.target;
				spd_reg <= umin(spd_next, end_sp);
			end else begin
				spd_reg <= spd_next;
				// A start from standstill steps in the wanted direction on its first tick
				pos_reg <= ((spd_reg == 32'h0) ? dir_want : dir_reg)
					? 32'(pos_reg - $signed(spd_next)) : 32'(pos_reg + $signed(spd_next));
				if (spd_reg == 32'h0)
					dir_reg <= dir_want;
			end
		end else if (tick_reg) begin
			// Idle after a nonzero end speed still winds down on the deceleration ramp
			spd_reg     <= spd_reg - umin(spd_reg, d_lim);
			acc_now_reg <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Velocity mode ramp generator

	logic signed [31:0] vl_vel_reg, vl_tgt;
	logic [31:0]        tv_mag, vl_rate, diff_m;
	logic               clamp_hit, slowing, ramp_hit, vl_lim_reg;
	logic signed [32:0] vl_diff;

	always_comb begin
		tv_mag    = sabs(i_vl.target);
		clamp_hit = 1'b0;
		if (tv_mag < i_vl.vmin) begin
			tv_mag    = i_vl.vmin;
			clamp_hit = 1'b1;
		end
		if (tv_mag > umin(i_vl.vmax, i_pp.max_motor_speed)) begin
			tv_mag    = umin(i_vl.vmax, i_pp.max_motor_speed);
			clamp_hit = 1'b1;
		end
		if (i_ctrl_word[mpse_pkg::CW_HALT] | i_quick_stop)
			vl_tgt = 32'h0;
		else
			vl_tgt = i_vl.target[31] ? 32'(-$signed(tv_mag)) : $signed(tv_mag);
		slowing = (sabs(vl_tgt) < sabs(vl_vel_reg)) | (vl_tgt[31] != vl_vel_reg[31]);
		if (i_quick_stop)
			vl_rate = rate_per_tick(i_vl.qs_dv, i_vl.qs_dt);
		else if (slowing)
			vl_rate = rate_per_tick(i_vl.dec_dv, i_vl.dec_dt);
		else
			vl_rate = rate_per_tick(i_vl.acc_dv, i_vl.acc_dt);
		vl_diff  = 33'(vl_tgt) - 33'(vl_vel_reg);
		diff_m   = vl_diff[32] ? 32'(-vl_diff) : 32'(vl_diff);
		ramp_hit = diff_m > vl_rate;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			vl_vel_reg <= 32'h0;
			vl_lim_reg <= 1'b0;
		end else if (!vl_mode) begin
			vl_vel_reg <= 32'h0;
			vl_lim_reg <= 1'b0;
		end else if (tick_reg) begin
			// Plain linear ramp here; the jerk settings are deliberately ignored
			if (!ramp_hit)
				vl_vel_reg <= vl_tgt;
			else if (vl_diff[32])
				vl_vel_reg <= 32'(vl_vel_reg - $signed(vl_rate));
			else
				vl_vel_reg <= 32'(vl_vel_reg + $signed(vl_rate));
			vl_lim_reg <= clamp_hit | ramp_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	logic signed [31:0] dem_vel;
	logic signed [63:0] rpm_full;

	always_comb begin
		if (vl_mode)
			dem_vel = vl_vel_reg;
		else
			dem_vel = dir_reg ? 32'(-$signed(spd_reg)) : $signed(spd_reg);
		// Divisor of zero passes the product through rather than trapping
		rpm_full = 64'(dem_vel) * $signed({32'h0, i_vl.dim_num});
		if (i_vl.dim_den != 32'h0)
			rpm_full = rpm_full / $signed({32'h0, i_vl.dim_den});
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_status_word <= mpse_pkg::STATUS_RST;
			o_trig_clear  <= 1'b0;
			o_demand_pos  <= 32'h0;
			o_demand_vel  <= 32'h0;
			o_vel_rpm     <= 32'h0;
		end else begin
			o_status_word                       <= mpse_pkg::STATUS_RST;
			o_status_word[mpse_pkg::SW_REACHED] <= pp_mode & reached_reg;
			o_status_word[mpse_pkg::SW_LIMIT]   <= vl_mode & vl_lim_reg;
			o_status_word[mpse_pkg::SW_SP_ACK]  <= pp_mode & ack_reg;
			o_trig_clear                        <= trig_clr_reg;
			o_demand_pos                        <= pos_reg;
			o_demand_vel                        <= dem_vel;
			o_vel_rpm                           <= 32'(rpm_full);
		end
	end

endmodule : mpse_engine

//--- mpse_engine_sva.sv
// Port-level assertion checker for the motion setpoint engine
`timescale 1ns/1ps
module mpse_engine_sva (
	input  wire logic                   i_mclk,
	input  wire logic                   i_rst_n,
	input  wire logic [7:0]             i_mode_op,
	input  wire logic [15:0]            i_ctrl_word,
	input  wire mpse_pkg::mpse_pp_cfg_s i_pp,
	input  wire logic [15:0]            o_status_word,
	input  wire logic                   o_trig_clear,
	input  wire logic signed [31:0]     o_demand_vel
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	logic [31:0] vlim;
	assign vlim = (i_pp.max_prof_vel < i_pp.max_motor_speed) ? i_pp.max_prof_vel
		: i_pp.max_motor_speed;

	////////////////////////////////////////////////////////////////////////////////
	reset_clear_a: assert property ($rose(i_rst_n) |->
		o_status_word == 16'h0000 && !o_trig_clear)
		else $error("outputs not cleared after reset");
	spare_bits_a: assert property ((o_status_word & 16'he3ff) == 16'h0000)
		else $error("unused status bits set");
	ack_cause_a: assert property ($rose(o_status_word[12]) |->
		$past(i_ctrl_word[4], 2) && $past(i_mode_op, 2) == mpse_pkg::MODE_PP)
		else $error("acknowledge without trigger");
	// With auto clear selected the engine treats the trigger as withdrawn by itself
	ack_clear_a: assert property ($fell(o_status_word[12]) |->
		!$past(i_ctrl_word[4], 2) || $past(i_mode_op, 2) != mpse_pkg::MODE_PP
		|| $past(i_pp.pos_option[5:4], 2) != 2'b00)
		else $error("acknowledge dropped while trigger high");
	trig_pulse_a: assert property (o_trig_clear |=> !o_trig_clear)
		else $error("trigger clear longer than one cycle");
	trig_with_ack_a: assert property (o_trig_clear |-> o_status_word[12])
		else $error("trigger clear without acknowledge");
	reached_mode_a: assert property ($rose(o_status_word[10]) |->
		$past(i_mode_op, 2) == mpse_pkg::MODE_PP)
		else $error("target reached outside position mode");
	limit_mode_a: assert property ($rose(o_status_word[11]) |->
		$past(i_mode_op, 2) == mpse_pkg::MODE_VL)
		else $error("limit flag outside velocity mode");
	speed_cap_a: assert property (i_mode_op == mpse_pkg::MODE_PP |->
		o_demand_vel <= $signed(vlim) && o_demand_vel >= -$signed(vlim))
		else $error("demand speed above limit");

	cover property ($rose(o_status_word[12]));
	cover property ($rose(o_status_word[10]));
	cover property (o_trig_clear);
	cover property ($rose(o_status_word[11]));
endmodule : mpse_engine_sva

bind mpse_engine mpse_engine_sva i_mpse_engine_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_mode_op(i_mode_op), .i_ctrl_word(i_ctrl_word), .i_pp(i_pp),
	.o_status_word(o_status_word), .o_trig_clear(o_trig_clear), .o_demand_vel(o_demand_vel));

//--- mpse_host.sv
// Fieldbus master model writing mode, target and control word objects
`timescale 1ns/1ps
module mpse_host #(
	parameter int TK = 8
) (
	input  wire logic          i_mclk,
	output logic [7:0]         o_mode_op,
	output logic [15:0]        o_ctrl_word,
	output logic signed [31:0] o_target_pos
);
	initial begin
		o_mode_op = 8'h00;
		o_ctrl_word = 16'h0000;
		o_target_pos = 32'sh0;
	end

	task automatic set_mode(input logic [7:0] m);
		@(negedge i_mclk);
		o_mode_op = m;
		repeat (2 * TK) @(negedge i_mclk);
	endtask : set_mode

	// Every write stands two ticks, so the engine samples each level at least once
	task automatic write_ctrl(input logic [15:0] bits);
		@(negedge i_mclk);
		o_ctrl_word = bits;
		repeat (2 * TK) @(negedge i_mclk);
	endtask : write_ctrl

	// Target lands one cycle before the trigger rises
	task automatic raise(input logic signed [31:0] tgt, input logic [15:0] bits);
		@(negedge i_mclk);
		o_target_pos = tgt;
		write_ctrl(bits | 16'h0010);
	endtask : raise
endmodule : mpse_host

//--- mpse_pkg.sv
// Shared constants and carrier types for the motion setpoint engine
package mpse_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_HZ      = 25_000_000;
	localparam int unsigned TICK_MS     = 1;
	localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TICKS_PER_S = 1000 / TICK_MS;

	////////////////////////////////////////////////////////////////////////////////
	// Control word and status word bit positions
	localparam int CW_NEW_SP    = 4;
	localparam int CW_IMMED     = 5;
	localparam int CW_RELATIVE  = 6;
	localparam int CW_HALT      = 8;
	localparam int CW_CHG_ON_SP = 9;
	localparam int SW_REACHED   = 10;
	localparam int SW_LIMIT     = 11;
	localparam int SW_SP_ACK    = 12;

	////////////////////////////////////////////////////////////////////////////////
	// Mode, profile type and positioning option encodings
	localparam logic [7:0]  MODE_PP      = 8'h01;
	localparam logic [7:0]  MODE_VL      = 8'h02;
	localparam logic [15:0] PROF_JERK    = 16'h0003;
	localparam logic [15:0] POC_REL_PREV = 16'h0000;
	localparam int          POC_CLR_LO   = 4;
	localparam int          POC_CLR_HI   = 5;
	localparam logic [15:0] STATUS_RST   = 16'h0000;

	typedef enum logic {MPSE_IDLE, MPSE_RUN} mpse_mv_e;

	// One travel command with its own limits
	typedef struct packed {
		logic signed [31:0] target;
		logic [31:0]        vel;
		logic [31:0]        end_vel;
		logic [31:0]        acc;
		logic [31:0]        dec;
	} mpse_move_s;

	// Profile position parameters
	typedef struct packed {
		logic [31:0]       prof_vel;
		logic [31:0]       end_vel;
		logic [31:0]       prof_acc;
		logic [31:0]       prof_dec;
		logic [31:0]       qs_dec;
		logic [31:0]       max_prof_vel;
		logic [31:0]       max_motor_speed;
		logic [31:0]       max_acc;
		logic [31:0]       max_dec;
		logic [15:0]       prof_type;
		logic [3:0][31:0]  jerk;
		logic [15:0]       pos_option;
	} mpse_pp_cfg_s;

	// Velocity mode parameters
	typedef struct packed {
		logic signed [31:0] target;
		logic [31:0]        vmin;
		logic [31:0]        vmax;
		logic [31:0]        acc_dv;
		logic [31:0]        acc_dt;
		logic [31:0]        dec_dv;
		logic [31:0]        dec_dt;
		logic [31:0]        qs_dv;
		logic [31:0]        qs_dt;
		logic [31:0]        dim_num;
		logic [31:0]        dim_den;
	} mpse_vl_cfg_s;

endpackage : mpse_pkg

//--- tb_top.sv
// Self-checking testbench for the motion setpoint engine
`timescale 1ns/1ps
module tb_top;
	localparam int TK = 8;
	logic                   i_mclk;
	logic                   i_rst_n;
	logic                   qs;
	logic [7:0]             mode;
	logic [15:0]            ctrl;
	logic signed [31:0]     tgt;
	mpse_pkg::mpse_pp_cfg_s pp;
	mpse_pkg::mpse_vl_cfg_s vl;
	logic [15:0]            sw;
	logic                   tclr;
	logic signed [31:0]     dpos;
	logic signed [31:0]     dvel;
	logic signed [31:0]     rpm;
	logic signed [31:0]     v0;
	int                     clr_cnt = 0;
	int                     c0;
	int                     miscompares;
	int                     checks;
	int                     cyc = 0;

	initial i_mclk = 1'b0;
	always #20 i_mclk = ~i_mclk;

	mpse_host #(.TK(TK)) i_mpse_host (.i_mclk(i_mclk), .o_mode_op(mode), .o_ctrl_word(ctrl),
		.o_target_pos(tgt));

	// Ideal axis: actual position follows demand
	mpse_engine #(.P_TICK_CYC(TK)) i_mpse_engine (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_mode_op(mode), .i_ctrl_word(ctrl), .i_quick_stop(qs), .i_target_pos(tgt),
		.i_actual_pos(dpos), .i_pp(pp),
		.i_vl(vl), .o_status_word(sw), .o_trig_clear(tclr), .o_demand_pos(dpos),
		.o_demand_vel(dvel), .o_vel_rpm(rpm));

	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (tclr === 1'b1)
			clr_cnt <= clr_cnt + 1;
		if (cyc == 10000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string msg);
		checks++;
		if (got !== want) begin
			miscompares++;
			$display("[FAIL] %0t %s: got %0h want %0h", $time, msg, got, want);
		end
	endtask : chk

	task automatic ticks(input int n);
		repeat (n * TK) @(negedge i_mclk);
	endtask : ticks

	task automatic tally_and_finish();
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_abs();
		c0 = clr_cnt;
		i_mpse_host.set_mode(mpse_pkg::MODE_PP);
		i_mpse_host.raise(32'sh28, 16'h0000);
		chk(32'(sw[12]), 32'h1, "ack");
		chk(32'(clr_cnt - c0), 32'h0, "no auto clear");
		i_mpse_host.write_ctrl(16'h0000);
		chk(dvel, 32'h4, "speed clamp");
		ticks(20);
		chk(dpos, 32'h28, "abs pos");
		chk(32'(sw[10]), 32'h1, "reached");
		chk(32'(sw[12]), 32'h0, "ack cleared");
		i_mpse_host.raise(32'sh1e, 16'h0040);
		i_mpse_host.write_ctrl(16'h0000);
		ticks(15);
		chk(dpos, 32'h46, "rel pos");
	endtask : t_abs

	// Second command fills the buffer, the third must be dropped
	task automatic t_buffer();
		i_mpse_host.raise(32'shc8, 16'h0000);
		i_mpse_host.write_ctrl(16'h0000);
		chk(32'(sw[12]), 32'h0, "buffer free");
		i_mpse_host.raise(32'sh78, 16'h0000);
		chk(32'(sw[12]), 32'h1, "buffered ack");
		i_mpse_host.write_ctrl(16'h0000);
		chk(32'(sw[12]), 32'h1, "ack held while full");
		i_mpse_host.raise(32'sh1f4, 16'h0000);
		i_mpse_host.write_ctrl(16'h0000);
		ticks(70);
		chk(dpos, 32'h78, "buffered pos");
	endtask : t_buffer

	task automatic t_immed();
		i_mpse_host.raise(32'sh190, 16'h0020);
		i_mpse_host.write_ctrl(16'h0020);
		i_mpse_host.raise(32'shfa, 16'h0020);
		i_mpse_host.write_ctrl(16'h0000);
		ticks(60);
		chk(dpos, 32'hfa, "immediate pos");
	endtask : t_immed

	task automatic t_autoclr();
		@(negedge i_mclk);
		pp.pos_option = 16'h0010;
		c0 = clr_cnt;
		i_mpse_host.raise(32'sh104, 16'h0000);
		chk(32'(clr_cnt - c0), 32'h1, "auto clear pulse");
		i_mpse_host.write_ctrl(16'h0000);
		ticks(10);
		chk(dpos, 32'h104, "auto clear pos");
	endtask : t_autoclr

	// Jerk step 1 and acceleration cap 3 shape the start; quick stop brakes by 5 per tick
	task automatic t_jerk();
		@(negedge i_mclk);
		pp.prof_type = 16'h0003;
		pp.jerk = {4{32'h1}};
		pp.prof_acc = 32'h4;
		pp.max_acc = 32'h3;
		pp.qs_dec = 32'h5;
		pp.max_motor_speed = 32'h40;
		i_mpse_host.raise(32'sh3e8, 16'h0000);
		while (dvel == 32'sh0)
			@(negedge i_mclk);
		chk(dvel, 32'h1, "jerk first step");
		ticks(2);
		chk(dvel, 32'h6, "jerk ramp");
		ticks(1);
		chk(dvel, 32'h9, "max acc step");
		ticks(1);
		chk(dvel, 32'ha, "speed limit");
		@(negedge i_mclk);
		qs = 1'b1;
		pp.prof_type = 16'h0000;
		ticks(1);
		v0 = dvel;
		ticks(1);
		chk(v0 - dvel, 32'h5, "quick stop step");
		@(negedge i_mclk);
		qs = 1'b0;
	endtask : t_jerk

	// Target 1000 is clamped to 50; ramps are 5 up and 10 down per tick
	task automatic t_vl();
		i_mpse_host.set_mode(mpse_pkg::MODE_VL);
		ticks(15);
		chk(dvel, 32'h32, "vl clamp");
		chk(32'(sw[11]), 32'h1, "limit flag");
		chk(rpm, 32'hbb8, "rpm");
		i_mpse_host.write_ctrl(16'h0100);
		v0 = dvel;
		ticks(1);
		chk(v0 - dvel, 32'ha, "decel step");
		ticks(8);
		chk(dvel, 32'h0, "halted");
		i_mpse_host.write_ctrl(16'h0000);
		v0 = dvel;
		ticks(1);
		chk(dvel - v0, 32'h5, "accel step");
		@(negedge i_mclk);
		vl.target = -32'sh3;
		vl.vmin = 32'h14;
		ticks(8);
		chk(dvel, 32'hffffffec, "vl min clamp");
		chk(32'(sw[11]), 32'h1, "min clamp flag");
	endtask : t_vl

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_rst_n = 1'b0;
		qs = 1'b0;
		miscompares = 0;
		checks = 0;
		pp = '{prof_vel: 32'ha, max_prof_vel: 32'h64, max_motor_speed: 32'h4, prof_acc: 32'h2,
			prof_dec: 32'h2, max_acc: 32'h2, max_dec: 32'h2, qs_dec: 32'h2, default: '0};
		// Deceleration delta written positive
		vl = '{target: 32'sh3e8, vmax: 32'h32, acc_dv: 32'h1388, acc_dt: 32'h1, dec_dv: 32'h2710,
			dec_dt: 32'h1, qs_dv: 32'h2710, qs_dt: 32'h1, dim_num: 32'h3c, dim_den: 32'h1,
			default: '0};
		repeat (12) @(negedge i_mclk);
		i_rst_n = 1'b1;
		chk(32'(sw), 32'h0, "reset status");
		t_abs();
		t_buffer();
		t_immed();
		t_autoclr();
		t_jerk();
		t_vl();
		tally_and_finish();
	end
endmodule : tb_top
